// *** adcsl_defines.vh ***
`ifndef ADCSL_DEFINES_VH
`define ADCSL_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADCSL_OFF_ENTRY    8'h08
`define ADCSL_OFF_CLEAR    8'h0c
`define ADCSL_OFF_LOAD     8'h10
`define ADCSL_OFF_ACQCLR   8'h14
`define ADCSL_OFF_CTRL     8'h18
`define ADCSL_OFF_STATUS   8'h1c
`define ADCSL_OFF_ACTIVE   8'h20

// ----------------------------------------------------------------
// Scan entry fields
// ----------------------------------------------------------------
`define ADCSL_F_SE         15
`define ADCSL_F_AIS        14
`define ADCSL_F_CAL        13
`define ADCSL_F_BIP        12
`define ADCSL_F_RSV_HI     11
`define ADCSL_F_RSV_LO     10
`define ADCSL_F_CHAN_HI    9
`define ADCSL_F_CHAN_LO    6
`define ADCSL_F_GAIN_HI    5
`define ADCSL_F_GAIN_LO    3
`define ADCSL_F_LAST       2
`define ADCSL_F_DISCARD    1
`define ADCSL_F_FWD        0

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define ADCSL_F_CTRL_SRC4  0
`define ADCSL_F_ST_FULL    31
`define ADCSL_F_ST_LOADED  30
`define ADCSL_F_ST_RD_LO   16
`define ADCSL_F_ST_CNT_LO  0

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define ADCSL_ENTRY_RST    16'h0000
`define ADCSL_CTRL_RST     1'b0
`define ADCSL_RESP_OKAY    2'b00
`define ADCSL_RESP_SLVERR  2'b10

// ----------------------------------------------------------------
// Amplifier input source codes
// ----------------------------------------------------------------
`define ADCSL_SRC_MUX      2'h0
`define ADCSL_SRC_GND      2'h1
`define ADCSL_SRC_SENSE    2'h2
`define ADCSL_SRC_VREF     2'h3

`endif

// *** adcsl_edge.v ***
`default_nettype none

module adcsl_edge #(
  parameter ACTIVE_LOW = 0
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Pin and detected edge
  input  wire pin,
  output reg  pulse
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;

  // ----------------------------------------------------------------
  // Three-stage capture; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q    <= (ACTIVE_LOW != 0);
      s2_q    <= (ACTIVE_LOW != 0);
      s3_q    <= (ACTIVE_LOW != 0);
      level_q <= (ACTIVE_LOW != 0);
      pulse   <= 1'b0;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pulse <= 1'b0;
      if (s2_q == s3_q && s3_q != level_q) begin
        level_q <= s3_q;
        pulse   <= (s3_q == (ACTIVE_LOW == 0));
      end
    end
  end

endmodule // adcsl_edge

`default_nettype wire

// *** adcsl_route.v ***
`default_nettype none
`include "adcsl_defines.vh"

module adcsl_route (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Active entry
  input  wire [15:0] entry,
  // Analog front-end controls
  output reg  [3:0]  mux_pos,
  output reg  [3:0]  mux_neg,
  output reg         mux_connect,
  output reg  [1:0]  amp_pos_src,
  output reg  [1:0]  amp_neg_src,
  output reg  [6:0]  amp_gain_value,
  output reg         amp_gain_invalid,
  output reg         bipolar_select
);

  wire [3:0] input_channel_code = entry[`ADCSL_F_CHAN_HI:`ADCSL_F_CHAN_LO];
  wire [2:0] amp_gain_code      = entry[`ADCSL_F_GAIN_HI:`ADCSL_F_GAIN_LO];
  wire       single_ended       = entry[`ADCSL_F_SE];
  wire       input_sense        = entry[`ADCSL_F_AIS];
  wire       calibration        = entry[`ADCSL_F_CAL];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_pos          <= 4'h0;
      mux_neg          <= 4'h0;
      mux_connect      <= 1'b0;
      amp_pos_src      <= `ADCSL_SRC_GND;
      amp_neg_src      <= `ADCSL_SRC_GND;
      amp_gain_value   <= 7'h00;
      amp_gain_invalid <= 1'b1;
      bipolar_select   <= 1'b0;
    end else begin
      bipolar_select <= entry[`ADCSL_F_BIP]; // RULE_01
      if (calibration) begin
        // Multiplexers are cut off so only internal levels reach the amplifier
        mux_connect <= 1'b0; // RULE_19
        amp_pos_src <= input_sense ? `ADCSL_SRC_VREF : `ADCSL_SRC_GND; // RULE_19
        amp_neg_src <= `ADCSL_SRC_GND;
        mux_pos     <= input_channel_code;
        mux_neg     <= 4'h0;
      end else if (single_ended) begin
        mux_connect <= 1'b1;
        mux_pos     <= input_channel_code; // RULE_03
        mux_neg     <= 4'h0;
        amp_pos_src <= `ADCSL_SRC_MUX;
        amp_neg_src <= input_sense ? `ADCSL_SRC_SENSE : `ADCSL_SRC_GND;
      end else begin
        mux_connect <= 1'b1;
        mux_pos     <= {1'b0, input_channel_code[2:0]}; // RULE_04
        mux_neg     <= {1'b1, input_channel_code[2:0]}; // RULE_04
        amp_pos_src <= `ADCSL_SRC_MUX;
        amp_neg_src <= `ADCSL_SRC_MUX;
      end
      amp_gain_invalid <= (amp_gain_code == 3'h0); // RULE_05
      case (amp_gain_code) // RULE_05
        3'h1:    amp_gain_value <= 7'h01;
        3'h2:    amp_gain_value <= 7'h02;
        3'h3:    amp_gain_value <= 7'h05;
        3'h4:    amp_gain_value <= 7'h0a;
        3'h5:    amp_gain_value <= 7'h14;
        3'h6:    amp_gain_value <= 7'h32;
        3'h7:    amp_gain_value <= 7'h64;
        default: amp_gain_value <= 7'h00;
      endcase
    end
  end

endmodule // adcsl_route

`default_nettype wire

// *** adcsl_scan_seq.v ***
`default_nettype none
`include "adcsl_defines.vh"

// Function
// RULE_01: Bipolar bit selects two's complement, sign extended
// RULE_02: Software writes reserved entry bits as zero
// RULE_03: Single-ended routes input equal to channel code
// RULE_04: Differential pair is code mod eight, plus eight
// RULE_05: Gain code maps to gain, zero invalid
// RULE_06: Sequence end flag marks last entry
// RULE_07: Discard flag converts but skips FIFO write
// RULE_08: Discarded conversions not counted in source mode
// RULE_09: Forward flag sends result to processor link
// RULE_10: Software clears list before writing entries
// RULE_11: Entry writes store and advance until full
// RULE_12: Load strobe makes first entry active
// RULE_13: Every conversion advances the active entry; one in the same cycle as a list clear or acquisition clear does not
// RULE_14: Read position wraps to first at end
// RULE_15: Acquisition clear rewinds, keeps entries, needs load
// RULE_16: Load strobe activates current entry and steps
// RULE_17: Single channel uses one written, loaded entry
// RULE_18: Memory holds 512 sixteen-bit entries
// RULE_19: Calibration flag cuts muxes, routes internal levels
// RULE_20: Active entry holds until next advance
module adcsl_scan_seq #(
  parameter DEPTH  = 512,
  parameter PTR_W  = 9,
  parameter FIFO_W = 32
) (
  // Clock and reset
  input  wire              clk,
  input  wire              reset_n,
  // AXI4-Lite slave
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Conversion sources and converter
  input  wire              external_convert_n,
  input  wire              timer3_out,
  input  wire              acq_clear_strobe,
  output reg               convert_start,
  input  wire              adc_done,
  input  wire [15:0]       adc_result,
  // Result handling
  output reg               fifo_wr_en,
  output reg  [FIFO_W-1:0] fifo_data,
  output reg               dsp_send,
  output reg  [15:0]       dsp_data,
  output reg               sample_count_en,
  output reg               sequence_end_flag,
  // Analog front-end
  output wire [3:0]        mux_pos,
  output wire [3:0]        mux_neg,
  output wire              mux_connect,
  output wire [1:0]        amp_pos_src,
  output wire [1:0]        amp_neg_src,
  output wire [6:0]        amp_gain_value,
  output wire              amp_gain_invalid,
  output wire              bipolar_select
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_s1_q;
  reg rst_n_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  reg        aw_have_q;
  reg [7:0]  aw_addr_q;
  reg        w_have_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        ctrl_src4_q;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;

  wire wr_fire  = aw_have_q & w_have_q;
  wire wr_lanes = |w_strb_q;
  wire wr_known = (aw_addr_q == `ADCSL_OFF_ENTRY)  || (aw_addr_q == `ADCSL_OFF_CLEAR) ||
                  (aw_addr_q == `ADCSL_OFF_LOAD)   || (aw_addr_q == `ADCSL_OFF_ACQCLR) ||
                  (aw_addr_q == `ADCSL_OFF_CTRL);
  wire wr_entry  = wr_fire & wr_lanes & (aw_addr_q == `ADCSL_OFF_ENTRY);
  wire wr_clear  = wr_fire & wr_lanes & (aw_addr_q == `ADCSL_OFF_CLEAR);
  wire wr_load   = wr_fire & wr_lanes & (aw_addr_q == `ADCSL_OFF_LOAD);
  wire wr_acqclr = wr_fire & wr_lanes & (aw_addr_q == `ADCSL_OFF_ACQCLR);

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_have_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ADCSL_RESP_OKAY;
      ctrl_src4_q  <= `ADCSL_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `ADCSL_RESP_OKAY : `ADCSL_RESP_SLVERR;
        if (aw_addr_q == `ADCSL_OFF_CTRL && w_strb_q[0])
          ctrl_src4_q <= w_data_q[`ADCSL_F_CTRL_SRC4];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan list memory and pointers
  // ----------------------------------------------------------------
  reg [15:0]    list_mem [0:DEPTH-1]; // RULE_18
  reg [PTR_W:0] count_q;
  reg [PTR_W:0] rd_q;
  reg [15:0]    active_q;
  reg           loaded_q;

  wire list_full = (count_q == DEPTH[PTR_W:0]);
  wire list_any  = (count_q != {(PTR_W+1){1'b0}});

  wire conv_ext;
  wire conv_tmr;
  wire conv_go = conv_ext | conv_tmr;

  adcsl_edge #(.ACTIVE_LOW(1)) u_edge_ext (
    .clk   (clk),
    .rst_n (rst_n_q),
    .pin   (external_convert_n),
    .pulse (conv_ext)
  );

  adcsl_edge #(.ACTIVE_LOW(0)) u_edge_tmr (
    .clk   (clk),
    .rst_n (rst_n_q),
    .pin   (timer3_out),
    .pulse (conv_tmr)
  );

  // Load and conversion in one cycle step the list once, not twice
  wire          step    = (wr_load | conv_go) & list_any; // RULE_13 RULE_16
  wire [PTR_W:0] rd_inc = rd_q + 1'b1;
  wire          rewind  = wr_acqclr | acq_clear_strobe;

  always @(posedge clk) begin
    if (wr_entry && !wr_clear && !list_full)
      list_mem[count_q[PTR_W-1:0]] <= w_data_q[15:0]; // RULE_11
  end

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q  <= {(PTR_W+1){1'b0}};
      rd_q     <= {(PTR_W+1){1'b0}};
      active_q <= `ADCSL_ENTRY_RST;
      loaded_q <= 1'b0;
    end else if (wr_clear) begin
      count_q  <= {(PTR_W+1){1'b0}};
      rd_q     <= {(PTR_W+1){1'b0}};
      loaded_q <= 1'b0;
    end else begin
      if (wr_entry && !list_full)
        count_q <= count_q + 1'b1; // RULE_11
      if (rewind) begin
        rd_q <= {(PTR_W+1){1'b0}}; // RULE_15
      end else if (step) begin
        active_q <= list_mem[rd_q[PTR_W-1:0]]; // RULE_12 RULE_20
        loaded_q <= 1'b1;
        rd_q     <= (rd_inc >= count_q) ? {(PTR_W+1){1'b0}} : rd_inc; // RULE_14
      end
    end
  end

  adcsl_route u_route (
    .clk              (clk),
    .rst_n            (rst_n_q),
    .entry            (active_q),
    .mux_pos          (mux_pos),
    .mux_neg          (mux_neg),
    .mux_connect      (mux_connect),
    .amp_pos_src      (amp_pos_src),
    .amp_neg_src      (amp_neg_src),
    .amp_gain_value   (amp_gain_value),
    .amp_gain_invalid (amp_gain_invalid),
    .bipolar_select   (bipolar_select)
  );

  // ----------------------------------------------------------------
  // Conversion bookkeeping
  // ----------------------------------------------------------------
  // Flags are captured at convert time; the list advances on the same edge,
  // so the result that follows must use the captured copy.
  reg conv_bip_q;
  reg conv_discard_q;
  reg conv_fwd_q;

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      convert_start     <= 1'b0;
      conv_bip_q        <= 1'b0;
      conv_discard_q    <= 1'b0;
      conv_fwd_q        <= 1'b0;
      sample_count_en   <= 1'b0;
      sequence_end_flag <= 1'b0;
      fifo_wr_en        <= 1'b0;
      fifo_data         <= {FIFO_W{1'b0}};
      dsp_send          <= 1'b0;
      dsp_data          <= 16'h0000;
    end else begin
      convert_start   <= conv_go & loaded_q;
      sample_count_en <= 1'b0;
      fifo_wr_en      <= 1'b0;
      dsp_send        <= 1'b0;
      sequence_end_flag <= active_q[`ADCSL_F_LAST]; // RULE_06
      if (conv_go && loaded_q) begin
        conv_bip_q     <= active_q[`ADCSL_F_BIP];
        conv_discard_q <= active_q[`ADCSL_F_DISCARD];
        conv_fwd_q     <= active_q[`ADCSL_F_FWD];
        sample_count_en <= ~(ctrl_src4_q & active_q[`ADCSL_F_DISCARD]); // RULE_08
      end
      if (adc_done) begin
        fifo_wr_en <= ~conv_discard_q; // RULE_07
        fifo_data  <= conv_bip_q ? {{(FIFO_W-16){adc_result[15]}}, adc_result} :
                                   {{(FIFO_W-16){1'b0}}, adc_result}; // RULE_01
        dsp_send   <= conv_fwd_q; // RULE_09
        dsp_data   <= adc_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  reg [31:0] rd_word;
  reg        rd_ok;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (ra)
      `ADCSL_OFF_CTRL: rd_word[`ADCSL_F_CTRL_SRC4] = ctrl_src4_q;
      `ADCSL_OFF_STATUS: begin
        rd_word[`ADCSL_F_ST_FULL]                  = list_full;
        rd_word[`ADCSL_F_ST_LOADED]                = loaded_q;
        rd_word[`ADCSL_F_ST_RD_LO+PTR_W:`ADCSL_F_ST_RD_LO]   = rd_q;
        rd_word[`ADCSL_F_ST_CNT_LO+PTR_W:`ADCSL_F_ST_CNT_LO] = count_q;
      end
      `ADCSL_OFF_ACTIVE: rd_word[15:0] = active_q;
      `ADCSL_OFF_ENTRY,
      `ADCSL_OFF_CLEAR,
      `ADCSL_OFF_LOAD,
      `ADCSL_OFF_ACQCLR: rd_word = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ADCSL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `ADCSL_RESP_OKAY : `ADCSL_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // adcsl_scan_seq

`default_nettype wire

// *** adcsl_conv_model.sv ***
`default_nettype none
module adcsl_conv_model (
  // Converter handshake
  input  wire logic        clk,
  input  wire logic        convert_start,
  output var  logic        adc_done,
  output var  logic [15:0] adc_result,
  // Bench controls: answer delay and sample
  input  wire logic [7:0]  lat,
  input  wire logic [15:0] value
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  initial begin
    wait_q = -1;
    adc_done = 1'b0;
    adc_result = 16'h0000;
  end
  always @(posedge clk) begin
    adc_done <= 1'b0;
    // Result is only valid with done, so it never holds a stale value
    adc_result <= ~adc_result;
    if (convert_start) begin
      wait_q <= lat;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (wait_q == 0) begin
      adc_done <= 1'b1;
      adc_result <= value;
      wait_q <= -1;
    end
  end
endmodule // adcsl_conv_model
`default_nettype wire

// *** adcsl_scan_seq_properties.sv ***
`default_nettype none
module adcsl_scan_seq_checker #(
  parameter FIFO_W = 32
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // Register bus
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  // Conversion and results
  input wire logic              convert_start,
  input wire logic              sample_count_en,
  input wire logic              adc_done,
  input wire logic [15:0]       adc_result,
  input wire logic              fifo_wr_en,
  input wire logic [FIFO_W-1:0] fifo_data,
  // Front-end controls
  input wire logic [3:0]        mux_pos,
  input wire logic [3:0]        mux_neg,
  input wire logic              mux_connect,
  input wire logic [1:0]        amp_pos_src,
  input wire logic [1:0]        amp_neg_src,
  input wire logic [6:0]        amp_gain_value,
  input wire logic              amp_gain_invalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_answer;
    s_axi_rvalid;
  endsequence
  sequence s_result_in;
    adc_done;
  endsequence

  property p_rd_answer;
    s_rd_take |=> s_rd_answer;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  // Upper bits must be all sign or all zero, never a mix
  property p_fifo_store;
    s_result_in ##1 fifo_wr_en |-> fifo_data[15:0] == $past(adc_result) &&
      (fifo_data[FIFO_W-1:16] == '0 || fifo_data[FIFO_W-1:16] == {(FIFO_W-16){fifo_data[15]}});
  endproperty
  property p_count;
    sample_count_en |-> convert_start;
  endproperty
  property p_gain;
    amp_gain_invalid == (amp_gain_value == 7'h00) &&
      amp_gain_value inside {7'h00, 7'h01, 7'h02, 7'h05, 7'h0a, 7'h14, 7'h32, 7'h64};
  endproperty
  property p_cal;
    !mux_connect |-> amp_neg_src == 2'h1 && amp_pos_src inside {2'h1, 2'h3};
  endproperty
  property p_differential_input;
    mux_connect && amp_neg_src == 2'h0 |-> mux_neg == {1'b1, mux_pos[2:0]} && !mux_pos[3];
  endproperty
  property p_se;
    mux_connect && amp_neg_src != 2'h0 |-> mux_neg == 4'h0 && amp_pos_src == 2'h0;
  endproperty

  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_fifo_store: assert property (p_fifo_store) else $error("fifo data wrong");
  a_count: assert property (p_count) else $error("count without conversion");
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  a_cal: assert property (p_cal) else $error("calibration routing wrong");
  a_differential_input: assert property (p_differential_input) else $error("differential pair wrong");
  a_se: assert property (p_se) else $error("single-ended routing wrong");
endmodule // adcsl_scan_seq_checker

bind adcsl_scan_seq adcsl_scan_seq_checker #(.FIFO_W(FIFO_W)) u_adcsl_scan_seq_checker (
  .clk(clk), .reset_n(reset_n), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .convert_start(convert_start), .adc_done(adc_done),
  .sample_count_en(sample_count_en), .adc_result(adc_result), .fifo_wr_en(fifo_wr_en),
  .fifo_data(fifo_data), .mux_pos(mux_pos), .mux_neg(mux_neg), .mux_connect(mux_connect),
  .amp_pos_src(amp_pos_src), .amp_neg_src(amp_neg_src), .amp_gain_value(amp_gain_value),
  .amp_gain_invalid(amp_gain_invalid)
);
`default_nettype wire

// *** tb.sv ***
`default_nettype none
`include "adcsl_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] e;
    logic [3:0]  p;
    logic [3:0]  n;
    logic [6:0]  g;
  } adcsl_row_t;
  localparam logic [1:0] OK = `ADCSL_RESP_OKAY;
  localparam int         NROW = 9;
  // Entry word, expected positive and negative input, expected gain
  adcsl_row_t rows [NROW] = '{
    {16'h83c8, 4'hf, 4'h0, 7'h01}, {16'hc010, 4'h0, 4'h0, 7'h02},
    {16'h0218, 4'h0, 4'h8, 7'h05}, {16'h11e0, 4'h7, 4'hf, 7'h0a},
    {16'h03e8, 4'h7, 4'hf, 7'h14}, {16'h8270, 4'h9, 4'h0, 7'h32},
    {16'h8138, 4'h4, 4'h0, 7'h64}, {16'h2000, 4'h0, 4'h0, 7'h00},
    {16'h6008, 4'h0, 4'h0, 7'h01}};
  logic        clk = 1'b0, reset_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lat = 8'h06;
  logic [31:0] wdata = 32'h0, rdata, fifo_data, last_ff = 32'h0, cnt = 32'h0, d;
  logic [15:0] adc_result, dsp_data;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ext_n = 1'b1, tmr = 1'b0, acq = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, conv_start, adc_done, fifo_wr_en;
  logic        dsp_send, count_en, seq_end, mux_connect, gain_invalid, bip;
  logic [1:0]  bresp, rresp, r, pos_src, neg_src;
  logic [3:0]  mux_pos, mux_neg;
  logic [6:0]  gain;
  int          fail_count = 0, check_count = 0;

  always #4 clk = ~clk;

  adcsl_scan_seq u_adcsl_scan_seq (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_convert_n(ext_n), .timer3_out(tmr), .acq_clear_strobe(acq),
    .convert_start(conv_start), .adc_done(adc_done), .adc_result(adc_result),
    .fifo_wr_en(fifo_wr_en), .fifo_data(fifo_data), .dsp_send(dsp_send), .dsp_data(dsp_data),
    .sample_count_en(count_en), .sequence_end_flag(seq_end), .mux_pos(mux_pos),
    .mux_neg(mux_neg), .mux_connect(mux_connect), .amp_pos_src(pos_src),
    .amp_neg_src(neg_src), .amp_gain_value(gain), .amp_gain_invalid(gain_invalid),
    .bipolar_select(bip)
  );
  adcsl_conv_model u_adcsl_conv_model (
    .clk(clk), .convert_start(conv_start), .adc_done(adc_done), .adc_result(adc_result),
    .lat(lat), .value(16'h8001)
  );

  // Per-byte event counts: start, counted, stored, forwarded
  always @(posedge clk) begin
    if (reset_n) begin
      cnt <= cnt + {7'h00, conv_start, 7'h00, count_en, 7'h00, fifo_wr_en, 7'h00, dsp_send};
      if (fifo_wr_en) last_ff <= fifo_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] mask, exp, input string m);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    chk(d & mask, exp, m);
  endtask

  task automatic check_row(input adcsl_row_t w);
    logic [4:0] src;
    src = w.e[13] ? {1'b0, w.e[14] ? `ADCSL_SRC_VREF : `ADCSL_SRC_GND, `ADCSL_SRC_GND} :
      {1'b1, `ADCSL_SRC_MUX, !w.e[15] ? `ADCSL_SRC_MUX :
       w.e[14] ? `ADCSL_SRC_SENSE : `ADCSL_SRC_GND};
    wr(`ADCSL_OFF_LOAD, 32'h1, OK);
    repeat (2) @(posedge clk);
    rdc(`ADCSL_OFF_ACTIVE, 32'hffff, {16'h0, w.e}, "active entry");
    if (!w.e[13]) chk({mux_pos, mux_neg}, {w.p, w.n}, "mux");
    chk({gain_invalid, gain}, {w.g == 7'h00, w.g}, "gain");
    chk({mux_connect, pos_src, neg_src}, src, "routing");
    chk(bip, w.e[12], "polarity");
  endtask

  task automatic conv(input logic t, input logic [31:0] exp, input string m);
    logic [31:0] c0;
    c0 = cnt;
    if (t) tmr <= 1'b1;
    else ext_n <= 1'b0;
    repeat (4) @(posedge clk);
    tmr <= 1'b0;
    ext_n <= 1'b1;
    for (int i = 0; i < 40 && cnt[31:24] == c0[31:24]; i++) @(posedge clk);
    repeat (12) @(posedge clk);
    chk(cnt - c0, exp, m);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(`ADCSL_OFF_STATUS, 32'hffffffff, 32'h0, "status at reset");
    rdc(`ADCSL_OFF_ENTRY, 32'hffffffff, 32'h0, "entry port reads zero");
    rdc(8'h04, 32'hffffffff, 32'h0, "unmapped read");
    chk(r, `ADCSL_RESP_SLVERR, "unmapped read response");
    wr(8'h04, 32'h1, `ADCSL_RESP_SLVERR);
    $display("test reset done");
    wr(`ADCSL_OFF_CLEAR, 32'h1, OK);
    foreach (rows[i]) wr(`ADCSL_OFF_ENTRY, {16'h0, rows[i].e}, OK);
    for (int k = 0; k <= NROW; k++) check_row(rows[k % NROW]);
    $display("test scan table done");
    wr(`ADCSL_OFF_CLEAR, 32'h1, OK);
    repeat (512) wr(`ADCSL_OFF_ENTRY, 32'h8008, OK);
    rdc(`ADCSL_OFF_STATUS, 32'h800003ff, 32'h80000200, "list full");
    wr(`ADCSL_OFF_ENTRY, 32'h8008, OK);
    rdc(`ADCSL_OFF_STATUS, 32'h800003ff, 32'h80000200, "write past full");
    $display("test full list done");
    wr(`ADCSL_OFF_CLEAR, 32'h1, OK);
    wr(`ADCSL_OFF_ENTRY, 32'h90c9, OK);
    wr(`ADCSL_OFF_ENTRY, 32'h814f, OK);
    wr(`ADCSL_OFF_ENTRY, 32'h8008, OK);
    wr(`ADCSL_OFF_CTRL, 32'h1, OK);
    wr(`ADCSL_OFF_LOAD, 32'h1, OK);
    conv(1'b0, 32'h01010101, "kept and forwarded");
    chk(last_ff, 32'hffff8001, "sign extended");
    chk(dsp_data, 32'h8001, "forwarded");
    rdc(`ADCSL_OFF_ACTIVE, 32'hffff, 32'h814f, "step by pin");
    chk(seq_end, 1'b1, "sequence end");
    lat <= 8'h00;
    conv(1'b1, 32'h01000001, "discarded");
    rdc(`ADCSL_OFF_ACTIVE, 32'hffff, 32'h8008, "step by timer");
    conv(1'b0, 32'h01010100, "unipolar");
    chk(last_ff, 32'h00008001, "zero extended");
    rdc(`ADCSL_OFF_ACTIVE, 32'hffff, 32'h90c9, "wrap");
    acq <= 1'b1;
    @(posedge clk) acq <= 1'b0;
    rdc(`ADCSL_OFF_STATUS, 32'h03ff03ff, 32'h00000003, "rewound");
    wr(`ADCSL_OFF_LOAD, 32'h1, OK);
    rdc(`ADCSL_OFF_STATUS, 32'h03ff0000, 32'h00010000, "reloaded");
    rdc(`ADCSL_OFF_ACTIVE, 32'hffff, 32'h90c9, "first entry");
    wr(`ADCSL_OFF_CLEAR, 32'h1, OK);
    wr(`ADCSL_OFF_ENTRY, 32'h8138, OK);
    repeat (2) wr(`ADCSL_OFF_LOAD, 32'h1, OK);
    rdc(`ADCSL_OFF_STATUS, 32'h43ff03ff, 32'h40000001, "one entry");
    $display("test conversions done");
    final_report;
  end

  // Some 546 writes of a few cycles each, plus margin
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule // tb
`default_nettype wire
